// file: pkg/mtid_pkg.sv
// shared constants and types of the motion threshold detector
package mtid_pkg;
    localparam int ACC_W             = 14;
    localparam int UNIT_SAMPLES      = 5;
    localparam int MOTION_STEP_SHIFT = 6;
    localparam int ADDR_W            = 8;

    localparam logic [7:0] ADDR_CTRL     = 8'h00;
    localparam logic [7:0] ADDR_FREEFALL = 8'h04;
    localparam logic [7:0] ADDR_SHOCK    = 8'h08;
    localparam logic [7:0] ADDR_MOTION   = 8'h0c;
    localparam logic [7:0] ADDR_STATUS   = 8'h10;

    localparam int CTRL_FF_EN     = 0;
    localparam int CTRL_SHOCK_EN  = 1;
    localparam int CTRL_MOT_INT   = 2;
    localparam int CTRL_MOT_ALERT = 3;
    localparam int CTRL_ADV       = 4;
    localparam int CTRL_LATCH     = 5;
    localparam int CTRL_TUNE_LO   = 6;
    localparam int CTRL_RST_INT   = 8;
    localparam int CTRL_FF_FILT   = 9;
    localparam int CTRL_SH_FILT   = 10;
    localparam int CTRL_MOT_FILT  = 11;
    localparam int CTRL_W         = 12;

    localparam int TH_LO   = 0;
    localparam int HY_LO   = 8;
    localparam int DUR_LO  = 16;
    localparam int CD_LO   = 24;
    localparam int AXEN_LO = 26;
    localparam int MDUR_LO = 8;
    localparam int MAX_LO  = 10;

    localparam logic [31:0] CTRL_RESET  = 32'h0000_0000;
    localparam logic [31:0] CFG_RESET   = 32'h0000_0000;
    localparam logic [31:0] MOTION_RESET = 32'h0000_0000;

    typedef enum logic [1:0] {
        MTID_CD_RESET = 2'h0,
        MTID_CD_DN1   = 2'h1,
        MTID_CD_DN2   = 2'h2,
        MTID_CD_DN3   = 2'h3
    } mtid_cd_t;

    // consecutive samples to flip the motion condition
    function automatic logic [2:0] mtid_need(input logic [1:0] code);
        return {code, 1'b1};
    endfunction

    // magnitude of a signed sample, saturated to 14'h1fff, the largest positive sample value
    function automatic logic [ACC_W-1:0] mtid_mag(input logic [ACC_W-1:0] v);
        logic [ACC_W-1:0] n;
        n = ~v + 14'h0001;
        if (!v[ACC_W-1])
            return v;
        else if (n[ACC_W-1])
            return 14'h1fff;
        else
            return n;
    endfunction
endpackage

// file: pkg/mtid_dbn_if.sv
// carrier between the detector and its debounce counters
`timescale 1ns/1ps
interface mtid_dbn_if;
    logic                  tick;
    logic                  enable;
    logic                  cond;
    logic [7:0]            duration;
    mtid_pkg::mtid_cd_t    mode;
    logic                  fire;
    logic [7:0]            count;
    modport ctl (output tick, output enable, output cond, output duration, output mode,
                 input fire, input count);
    modport cnt (input tick, input enable, input cond, input duration, input mode,
                 output fire, output count);
endinterface

// file: core/mtid_debounce.sv
// debounce counter for the freefall and shock detectors
`timescale 1ns/1ps
module mtid_debounce (
    input  wire logic clock,
    input  wire logic rst_n,
    mtid_dbn_if.cnt   dbn
);
    logic [7:0] next_count;
    logic       hit;

    always_comb
    begin
        next_count = dbn.count;
        hit        = 1'b0;
        if (!dbn.enable)
            next_count = 8'h00;
        else if (dbn.cond && dbn.duration == 8'h00)
        begin
            hit        = 1'b1;
            next_count = 8'h00;
        end
        else if (dbn.tick)
        begin
            if (dbn.cond)
            begin
                if (dbn.count + 8'h01 == dbn.duration)
                begin
                    hit        = 1'b1;
                    next_count = 8'h00;
                end
                else
                    next_count = dbn.count + 8'h01;
            end
            else
            begin
                unique case (dbn.mode)
                    mtid_pkg::MTID_CD_RESET: next_count = 8'h00;
                    mtid_pkg::MTID_CD_DN1:
                        next_count = (dbn.count > 8'h01) ? dbn.count - 8'h01 : 8'h00;
                    mtid_pkg::MTID_CD_DN2:
                        next_count = (dbn.count > 8'h02) ? dbn.count - 8'h02 : 8'h00;
                    mtid_pkg::MTID_CD_DN3:
                        next_count = (dbn.count > 8'h03) ? dbn.count - 8'h03 : 8'h00;
                endcase
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            dbn.count <= 8'h00;
            dbn.fire  <= 1'b0;
        end
        else
        begin
            dbn.count <= next_count;
            dbn.fire  <= hit;
        end
    end

    property p_dbn_hit;
        @(posedge clock) disable iff (!rst_n)
        (dbn.enable && dbn.tick && dbn.cond && dbn.duration != 8'h00
         && dbn.count + 8'h01 == dbn.duration) |=> (dbn.fire && dbn.count == 8'h00);
    endproperty
    a_dbn_hit: assert property (p_dbn_hit) else $error("counter did not fire at duration");

    property p_dbn_reset;
        @(posedge clock) disable iff (!rst_n)
        (dbn.enable && dbn.tick && !dbn.cond && dbn.mode == mtid_pkg::MTID_CD_RESET)
        |=> dbn.count == 8'h00;
    endproperty
    a_dbn_reset: assert property (p_dbn_reset) else $error("countdown reset mode failed");

    property p_dbn_inc;
        @(posedge clock) disable iff (!rst_n)
        (dbn.enable && dbn.tick && dbn.cond && dbn.duration != 8'h00
         && dbn.count + 8'h01 != dbn.duration) |=> dbn.count == $past(dbn.count) + 8'h01;
    endproperty
    a_dbn_inc: assert property (p_dbn_inc) else $error("counter did not step up");
endmodule

// file: core/mtid_top.sv
// freefall, shock and motion detectors with an ahb-lite register file
//
// The register addresses and the AHB-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
module mtid_top #(
    parameter int ACC_W = mtid_pkg::ACC_W
) (
    input  wire logic                 clock,
    input  wire logic                 rst_n,
    input  wire logic                 hsel,
    input  wire logic [7:0]           haddr,
    input  wire logic [1:0]           htrans,
    input  wire logic                 hwrite,
    input  wire logic [2:0]           hsize,
    input  wire logic                 hready,
    input  wire logic [31:0]          hwdata,
    output logic      [31:0]          hrdata,
    output logic                      hreadyout,
    output logic                      hresp,
    input  wire logic                 sample_valid,
    input  wire logic [3*ACC_W-1:0]   raw_acc,
    input  wire logic                 filt_valid,
    input  wire logic [3*ACC_W-1:0]   filt_acc,
    output logic                      int_out,
    output logic                      alert_mode
);
    logic [31:0]      ctrl;
    logic [31:0]      ff_cfg;
    logic [31:0]      sh_cfg;
    logic [31:0]      mot_cfg;
    logic             wr_pend;
    logic [7:0]       wr_addr;
    logic             rst_int;
    logic [2:0]       unit_cnt;
    logic             tick;
    logic             ff_cond;
    logic             sh_cond;
    logic             ff_active;
    logic             sh_active;
    logic             mot_active;
    logic [2:0]       sh_sign;
    logic [2:0]       mot_sign;
    logic             mot_cond;
    logic [2:0]       mot_run;
    logic             prev_ok;
    logic [3*ACC_W-1:0] prev_acc;

    mtid_dbn_if ff_dbn ();
    mtid_dbn_if sh_dbn ();

    // zero-wait slave: read data is latched in the address phase
    wire addr_ok = hsel && hready && htrans[1];
    wire [31:0] status = {20'h00000, int_out, mot_cond, mot_sign, sh_sign,
                          alert_mode, mot_active, sh_active, ff_active};

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            wr_pend   <= 1'b0;
            wr_addr   <= 8'h00;
        end
        else
        begin
            wr_pend <= addr_ok && hwrite;
            wr_addr <= haddr;
            if (addr_ok && !hwrite)
            begin
                unique case (haddr)
                    mtid_pkg::ADDR_CTRL:     hrdata <= ctrl;
                    mtid_pkg::ADDR_FREEFALL: hrdata <= ff_cfg;
                    mtid_pkg::ADDR_SHOCK:    hrdata <= sh_cfg;
                    mtid_pkg::ADDR_MOTION:   hrdata <= mot_cfg;
                    mtid_pkg::ADDR_STATUS:   hrdata <= status;
                    default:                 hrdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl    <= mtid_pkg::CTRL_RESET;
            ff_cfg  <= mtid_pkg::CFG_RESET;
            sh_cfg  <= mtid_pkg::CFG_RESET;
            mot_cfg <= mtid_pkg::MOTION_RESET;
            rst_int <= 1'b0;
        end
        else
        begin
            rst_int <= 1'b0;
            if (wr_pend)
            begin
                unique case (wr_addr)
                    mtid_pkg::ADDR_CTRL:
                    begin
                        ctrl    <= {20'h00000, hwdata[11:9], 1'b0, hwdata[7:0]};
                        rst_int <= hwdata[mtid_pkg::CTRL_RST_INT];
                    end
                    mtid_pkg::ADDR_FREEFALL: ff_cfg  <= {6'h00, hwdata[25:0]};
                    mtid_pkg::ADDR_SHOCK:    sh_cfg  <= {3'h0, hwdata[28:0]};
                    mtid_pkg::ADDR_MOTION:   mot_cfg <= {19'h00000, hwdata[12:0]};
                    default:                 rst_int <= 1'b0;
                endcase
            end
        end
    end

    // enables; both motion uses blocked if both are requested
    wire latch    = ctrl[mtid_pkg::CTRL_LATCH];
    wire adv      = ctrl[mtid_pkg::CTRL_ADV];
    wire both_mot = ctrl[mtid_pkg::CTRL_MOT_INT] && ctrl[mtid_pkg::CTRL_MOT_ALERT];
    wire mot_int_en = adv && ctrl[mtid_pkg::CTRL_MOT_INT] && !both_mot;
    wire mot_alr_en = adv && ctrl[mtid_pkg::CTRL_MOT_ALERT] && !both_mot;
    wire ff_en = ctrl[mtid_pkg::CTRL_FF_EN] && ctrl[7:6] == 2'h0;
    wire sh_en = ctrl[mtid_pkg::CTRL_SHOCK_EN];

    // one debounce unit is five sample periods, independent of bandwidth
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            unit_cnt <= 3'h0;
            tick     <= 1'b0;
        end
        else
        begin
            tick <= 1'b0;
            if (sample_valid)
            begin
                if (unit_cnt == 3'(mtid_pkg::UNIT_SAMPLES - 1))
                begin
                    unit_cnt <= 3'h0;
                    tick     <= 1'b1;
                end
                else
                    unit_cnt <= unit_cnt + 3'h1;
            end
        end
    end

    // threshold comparisons on top eight magnitude bits
    wire ff_stb = ctrl[mtid_pkg::CTRL_FF_FILT] ? filt_valid : sample_valid;
    wire sh_stb = ctrl[mtid_pkg::CTRL_SH_FILT] ? filt_valid : sample_valid;
    logic [2:0] ff_below;
    logic [2:0] sh_above;
    logic [2:0] sh_neg;
    logic [2:0] sh_hit;
    logic [2:0] sh_hit_neg;
    always_comb
    begin
        logic [ACC_W-1:0] fa;
        logic [ACC_W-1:0] sa;
        logic [ACC_W-1:0] fm;
        logic [ACC_W-1:0] sm;
        logic [8:0]       ff_lim;
        logic [8:0]       sh_lim;
        fa     = '0;
        sa     = '0;
        fm     = '0;
        sm     = '0;
        // hysteresis widens the window only while the source is active
        ff_lim = {1'b0, ff_cfg[7:0]} + (ff_active ? {1'b0, ff_cfg[15:8]} : 9'h000);
        sh_lim = {1'b0, sh_cfg[7:0]} - (sh_active ? {1'b0, sh_cfg[15:8]} : 9'h000);
        if (sh_active && sh_cfg[15:8] > sh_cfg[7:0])
            sh_lim = 9'h000;
        for (int a = 0; a < 3; a++)
        begin
            fa = ctrl[mtid_pkg::CTRL_FF_FILT] ? filt_acc[a*ACC_W +: ACC_W]
                                              : raw_acc[a*ACC_W +: ACC_W];
            sa = ctrl[mtid_pkg::CTRL_SH_FILT] ? filt_acc[a*ACC_W +: ACC_W]
                                              : raw_acc[a*ACC_W +: ACC_W];
            fm = mtid_pkg::mtid_mag(fa);
            sm = mtid_pkg::mtid_mag(sa);
            ff_below[a] = {1'b0, fm[ACC_W-1 -: 8]} < ff_lim;
            sh_above[a] = sh_cfg[mtid_pkg::AXEN_LO + a]
                       && {1'b0, sm[ACC_W-1 -: 8]} > sh_lim;
            sh_neg[a]   = sa[ACC_W-1];
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ff_cond    <= 1'b0;
            sh_cond    <= 1'b0;
            sh_hit     <= 3'h0;
            sh_hit_neg <= 3'h0;
        end
        else
        begin
            if (ff_stb)
                ff_cond <= &ff_below;
            // sign kept from the strobed sample; live data may have moved on by the fire
            if (sh_stb)
            begin
                sh_cond    <= |sh_above;
                sh_hit     <= sh_above;
                sh_hit_neg <= sh_neg;
            end
        end
    end

    assign ff_dbn.tick     = tick;
    assign ff_dbn.enable   = ff_en;
    assign ff_dbn.cond     = ff_cond;
    assign ff_dbn.duration = ff_cfg[mtid_pkg::DUR_LO +: 8];
    assign ff_dbn.mode     = mtid_pkg::mtid_cd_t'(ff_cfg[mtid_pkg::CD_LO +: 2]);
    assign sh_dbn.tick     = tick;
    assign sh_dbn.enable   = sh_en;
    assign sh_dbn.cond     = sh_cond;
    assign sh_dbn.duration = sh_cfg[mtid_pkg::DUR_LO +: 8];
    assign sh_dbn.mode     = mtid_pkg::mtid_cd_t'(sh_cfg[mtid_pkg::CD_LO +: 2]);

    mtid_debounce u_ff_dbn (
        .clock (clock),
        .rst_n (rst_n),
        .dbn   (ff_dbn.cnt)
    );

    mtid_debounce u_sh_dbn (
        .clock (clock),
        .rst_n (rst_n),
        .dbn   (sh_dbn.cnt)
    );

    // slope on the selected stream; first sample only primes history
    wire mot_stb = ctrl[mtid_pkg::CTRL_MOT_FILT] ? filt_valid : sample_valid;
    logic [2:0] mot_over;
    logic [2:0] mot_neg;
    always_comb
    begin
        logic [ACC_W:0] d;
        logic [ACC_W:0] m;
        d = '0;
        m = '0;
        for (int a = 0; a < 3; a++)
        begin
            d = ctrl[mtid_pkg::CTRL_MOT_FILT]
              ? {filt_acc[a*ACC_W+ACC_W-1], filt_acc[a*ACC_W +: ACC_W]}
                - {prev_acc[a*ACC_W+ACC_W-1], prev_acc[a*ACC_W +: ACC_W]}
              : {raw_acc[a*ACC_W+ACC_W-1], raw_acc[a*ACC_W +: ACC_W]}
                - {prev_acc[a*ACC_W+ACC_W-1], prev_acc[a*ACC_W +: ACC_W]};
            m = d[ACC_W] ? ~d + 15'h0001 : d;
            mot_over[a] = mot_cfg[mtid_pkg::MAX_LO + a]
                       && (m >> mtid_pkg::MOTION_STEP_SHIFT) > {7'h00, mot_cfg[7:0]};
            mot_neg[a]  = d[ACC_W];
        end
    end

    wire mot_raw = prev_ok && |mot_over;
    wire [2:0] need = mtid_pkg::mtid_need(mot_cfg[mtid_pkg::MDUR_LO +: 2]);

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            prev_acc <= '0;
            prev_ok  <= 1'b0;
            mot_cond <= 1'b0;
            mot_run  <= 3'h0;
            mot_sign <= 3'h0;
        end
        else if (mot_stb)
        begin
            prev_acc <= ctrl[mtid_pkg::CTRL_MOT_FILT] ? filt_acc : raw_acc;
            prev_ok  <= 1'b1;
            // set and reset are both filtered by the same run length
            if (mot_raw == mot_cond)
                mot_run <= 3'h0;
            else if (mot_run + 3'h1 >= need)
            begin
                mot_cond <= mot_raw;
                mot_run  <= 3'h0;
            end
            else
                mot_run <= mot_run + 3'h1;
            for (int a = 0; a < 3; a++)
                if (mot_over[a] && prev_ok)
                    mot_sign[a] <= mot_neg[a];
        end
    end

    // sources: set wins over the clear from software
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ff_active  <= 1'b0;
            sh_active  <= 1'b0;
            mot_active <= 1'b0;
            sh_sign    <= 3'h0;
        end
        else
        begin
            if (ff_dbn.fire)
                ff_active <= 1'b1;
            else if (!ff_en || (latch ? rst_int : !ff_cond))
                ff_active <= 1'b0;
            if (sh_dbn.fire)
            begin
                sh_active <= 1'b1;
                for (int a = 0; a < 3; a++)
                    if (sh_hit[a])
                        sh_sign[a] <= sh_hit_neg[a];
            end
            else if (!sh_en || (latch ? rst_int : !sh_cond))
                sh_active <= 1'b0;
            if (mot_int_en && mot_cond)
                mot_active <= 1'b1;
            else if (!mot_int_en || (latch ? rst_int : !mot_cond))
                mot_active <= 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            int_out    <= 1'b0;
            alert_mode <= 1'b0;
        end
        else
        begin
            int_out    <= ff_active || sh_active || mot_active;
            alert_mode <= mot_alr_en && mot_cond;
        end
    end

    property p_ff_all;
        @(posedge clock) disable iff (!rst_n)
        $rose(ff_cond) |-> $past(&ff_below && ff_stb);
    endproperty
    a_ff_all: assert property (p_ff_all) else $error("freefall set without all axes low");

    property p_nonlatch_clr;
        @(posedge clock) disable iff (!rst_n)
        (!latch && sh_active && !sh_cond && !sh_dbn.fire) |=> !sh_active;
    endproperty
    a_nonlatch_clr: assert property (p_nonlatch_clr) else $error("shock did not clear");

    property p_latch_hold;
        @(posedge clock) disable iff (!rst_n)
        (latch && ff_active && ff_en && !rst_int) |=> ff_active;
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("latched freefall dropped");

    property p_int_or;
        @(posedge clock) disable iff (!rst_n)
        (sh_dbn.fire && sh_en) |=> sh_active ##1 int_out;
    endproperty
    a_int_or: assert property (p_int_or) else $error("shock fire not seen on output");

    property p_adv_gate;
        @(posedge clock) disable iff (!rst_n)
        !adv [*2] |-> !alert_mode && !$rose(mot_active);
    endproperty
    a_adv_gate: assert property (p_adv_gate) else $error("motion acted without gate");

    property p_tick;
        @(posedge clock) disable iff (!rst_n)
        (sample_valid && unit_cnt == 3'h4) |=> tick ##1 !tick;
    endproperty
    a_tick: assert property (p_tick) else $error("unit tick missing");

    property p_mot_run;
        @(posedge clock) disable iff (!rst_n)
        $changed(mot_cond) |-> $past(mot_run) + 3'h1 >= $past(need) && $past(mot_stb);
    endproperty
    a_mot_run: assert property (p_mot_run) else $error("motion flipped before run");

    property p_tune_block;
        @(posedge clock) disable iff (!rst_n)
        (ctrl[7:6] != 2'h0) [*2] |=> !ff_active;
    endproperty
    a_tune_block: assert property (p_tune_block) else $error("freefall active while tuning");

    c_ff_fire:  cover property (@(posedge clock) disable iff (!rst_n) $rose(ff_active));
    c_sh_fire:  cover property (@(posedge clock) disable iff (!rst_n) $rose(sh_active));
    c_mot_int:  cover property (@(posedge clock) disable iff (!rst_n) $rose(mot_active));
    c_alert:    cover property (@(posedge clock) disable iff (!rst_n) $rose(alert_mode));
endmodule

// file: test/mtid_host_model.sv
// host side model that watches the interrupt and alert pins
`timescale 1ns/1ps
module mtid_host_model (
    input  wire logic clock,
    input  wire logic int_out,
    input  wire logic alert_mode,
    output int        n_irq
);
    logic prev = 1'h0;
    initial n_irq = 0;
    // host reacts to a rising level only, as a pin interrupt would
    always @(posedge clock)
    begin
        if ((int_out || alert_mode) && !prev)
            n_irq <= n_irq + 1;
        prev <= int_out || alert_mode;
    end
endmodule

// file: test/mtid_top_tb_top.sv
// self-checking bench of the motion threshold detector
`timescale 1ns/1ps
module mtid_top_tb_top;
    logic        clock = 1'h0;
    logic        rst_n = 1'h0;
    logic        hsel = 1'h0;
    logic [7:0]  haddr = 8'h00;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        sv = 1'h0;
    logic        fv = 1'h0;
    logic [41:0] acc = 42'h0;
    logic        int_out;
    logic        alert_mode;
    logic [31:0] lfsr = 32'h0750cbef;
    logic [31:0] q;
    int          failures = 0;
    int          n_tests = 0;
    int          cyc = 0;
    int          n_irq;

    mtid_top mtid_top_i (.clock(clock), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout),
        .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(),
        .sample_valid(sv), .raw_acc(acc), .filt_valid(fv), .filt_acc(acc),
        .int_out(int_out), .alert_mode(alert_mode));
    mtid_host_model mtid_host_model_i (.clock(clock), .int_out(int_out),
        .alert_mode(alert_mode), .n_irq(n_irq));

    always #5 clock = ~clock;

    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic int m8(input int v);
        return (v < 0 ? -v : v) >> 6;
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            failures++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // single word transfer; waits on hready in both phases
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        hsel <= 1'h1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        @(posedge clock);
        while (hreadyout !== 1'h1)
            @(posedge clock);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clock);
        while (hreadyout !== 1'h1)
            @(posedge clock);
        q = hrdata;
        hsel <= 1'h0;
    endtask

    task automatic rst();
        rst_n <= 1'h0;
        repeat (2) @(posedge clock);
        rst_n <= 1'h1;
    endtask

    // one sample strobe; data scrambled afterwards so stale values never match
    task automatic smp(input logic f, input int x, input int y, input int z, input int w);
        @(posedge clock);
        sv <= !f;
        fv <= f;
        acc <= {z[13:0], y[13:0], x[13:0]};
        @(posedge clock);
        sv <= 1'h0;
        fv <= 1'h0;
        acc <= ~acc;
        repeat (w) @(posedge clock);
    endtask

    // ramp of n slopes then n flat samples on x
    task automatic mot(input logic [31:0] ctl, input int code, input logic ei, input logic ea);
        int         n;
        logic [1:0] e;
        n = 2 * code + 1;
        rst();
        bus(1'h1, 8'h0c, {19'h0, 3'h1, code[1:0], 8'h0e});
        bus(1'h1, 8'h00, ctl);
        smp(1'h0, 0, 0, 0, 6);
        for (int k = 1; k <= 2 * n; k++)
        begin
            smp(1'h0, -1000 * ((k > n) ? n : k), 0, 0, 6);
            e = {ea, ei} & {2{k >= n && k < 2 * n}};
            chk({alert_mode, int_out}, e);
        end
        bus(1'h0, 8'h10, 32'h0);
        chk(q[7], !ctl[11]);
    endtask

    always @(posedge clock)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            failures++;
            $display("ERROR %0t: timeout", $time);
            give_verdict();
        end
    end

    initial
    begin
        int v;
        int c;
        repeat (10) @(posedge clock);
        rst_n <= 1'h1;
        lfsr = nxt(lfsr);
        bus(1'h1, 8'h04, lfsr);
        bus(1'h0, 8'h04, 32'h0);
        chk(q, lfsr & 32'h03ff_ffff);
        bus(1'h0, 8'h40, 32'h0);
        chk(q, 32'h0);
        bus(1'h1, 8'h00, 32'h0000_0120);
        bus(1'h0, 8'h00, 32'h0);
        chk(q, 32'h0000_0020);
        bus(1'h1, 8'h08, 32'h0400_0040);
        bus(1'h1, 8'h00, 32'h0000_0002);
        for (int i = 0; i < 8; i++)
        begin
            lfsr = nxt(lfsr);
            v = int'(lfsr % 16000) - 8000;
            smp(1'h0, (i % 2) ? v : 0, (i % 2) ? 0 : v, 0, 6);
            chk(int_out, (i % 2) && m8(v) > 8'h40);
        end
        for (int cd = 0; cd < 4; cd++)
        begin
            rst();
            bus(1'h1, 8'h08, {3'h0, 3'h1, cd[1:0], 24'h04_0040});
            bus(1'h1, 8'h00, 32'h0000_0002);
            repeat (15) smp(1'h0, 6000, 0, 0, 0);
            repeat (5) smp(1'h0, 0, 0, 0, 0);
            c = (cd == 0) ? 0 : 3 - cd;
            for (int b = 0; b < 4; b++)
            begin
                repeat (5) smp(1'h0, 6000, 0, 0, 0);
                repeat (6) @(posedge clock);
                chk(int_out, b + 1 >= 4 - c);
            end
        end
        rst();
        bus(1'h1, 8'h08, 32'h0400_0040);
        bus(1'h1, 8'h00, 32'h0000_0422);
        smp(1'h1, -6000, 0, 0, 6);
        smp(1'h1, 0, 0, 0, 6);
        chk(int_out, 1'h1);
        bus(1'h0, 8'h10, 32'h0);
        chk(q[6:4], 3'h1);
        bus(1'h1, 8'h00, 32'h0000_0522);
        repeat (4) @(posedge clock);
        chk(int_out, 1'h0);
        rst();
        bus(1'h1, 8'h04, 32'h0000_0010);
        bus(1'h1, 8'h00, 32'h0000_0241);
        smp(1'h1, 500, -500, 900, 6);
        chk(int_out, 1'h0);
        bus(1'h1, 8'h00, 32'h0000_0201);
        smp(1'h1, 500, -500, 900, 6);
        chk(int_out, 1'h1);
        smp(1'h1, 500, 5000, 900, 6);
        chk(int_out, 1'h0);
        smp(1'h0, 0, 0, 0, 6);
        chk(int_out, 1'h0);
        for (int k = 0; k < 4; k++)
            mot(32'h14, k, 1'h1, 1'h0);
        mot(32'h04, 0, 1'h0, 1'h0);
        mot(32'h1c, 0, 1'h0, 1'h0);
        mot(32'h18, 0, 1'h0, 1'h1);
        mot(32'h814, 0, 1'h0, 1'h0);
        chk(n_irq != 0, 1'h1);
        give_verdict();
    end
endmodule
